// [pkg/cdf_consts.svh]
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the package and verification files
`ifndef CDF_CONSTS_SVH
`define CDF_CONSTS_SVH
// Channel address offsets
`define CDF_ADDR_RES_DEC      10'h090
`define CDF_ADDR_RES_INT      10'h091
`define CDF_ADDR_RES_SCALE    10'h092
`define CDF_ADDR_RSVD_A       10'h093
`define CDF_ADDR_C5_DEC       10'h094
`define CDF_ADDR_C5_SCALE     10'h095
`define CDF_ADDR_RSVD_B       10'h096
`define CDF_ADDR_CF_DEC       10'h0A0
`define CDF_ADDR_CF_PHASE     10'h0A1
`define CDF_ADDR_CF_TAPS      10'h0A2
`define CDF_ADDR_CF_OFFSET    10'h0A3
`define CDF_ADDR_CF_CTRL      10'h0A4
`define CDF_ADDR_SIG_I        10'h0A5
`define CDF_ADDR_SIG_Q        10'h0A6
`define CDF_ADDR_SIG_COUNT    10'h0A7
`define CDF_ADDR_MEM_TEST     10'h0A8
`define CDF_ADDR_SER_CTRL     10'h0A9
`define CDF_ADDR_COEF_TOP     10'h07F
// Field positions
`define CDF_SC_EXP_POL        11
`define CDF_SC_EXP_WT         10
`define CDF_CTL_BYPASS        10
`define CDF_CTL_SRC           9
`define CDF_CTL_COEFFICIENT_MEMORY_HI       8
`define CDF_CTL_SHARED_EXP    7
`define CDF_CTL_FORCE_SCALE   6
`define CDF_SER_MAP           9
`define CDF_MT_START          0
`define CDF_MT_COEFFICIENT_MEMORY_FAIL      1
`define CDF_MT_DMEM_FAIL      2
// Reset values
`define CDF_RST_ZERO          20'h00000
// Timing: memory test length in clocks
`define CDF_MEMTEST_CLKS      1600
`endif

// [pkg/cdf_pkg.sv]
// Types shared by the channel decimation filter configuration logic
// Assumes cdf_consts.svh is on the include path
package cdf_pkg;
   `include "cdf_consts.svh"
   // Output formatting modes
   typedef enum logic [1:0] {
      CDF_FMT_FIXED,
      CDF_FMT_FLOAT8,
      CDF_FMT_FLOAT12
   } cdf_fmt_t;
   // Signature engine states
   typedef enum logic [1:0] {
      CDF_SIG_IDLE,
      CDF_SIG_RUN,
      CDF_SIG_DONE
   } cdf_sig_t;
endpackage : cdf_pkg

// [logic/cdf_channel_cfg.sv]
// Per-channel decimation chain configuration, readback and self-test
// Assumes a host write/read strobe port already decoded to channel address
`timescale 1ns/1ps
module cdf_channel_cfg
   import cdf_pkg::*;
#(
   parameter logic [1:0] CHANNEL_ID = 2'h0   // Position of this channel
)(
   // Clock and reset
   input  wire logic         clk_in,
   input  wire logic         nrst_in,
   // Host register access
   input  wire logic         wr_en_in,
   input  wire logic         rd_en_in,
   input  wire logic [9:0]   addr_in,
   input  wire logic [19:0]  wdata_in,
   output logic      [19:0]  rdata_out,
   output logic              rvalid_out,
   // Channel state
   input  wire logic         sleep_in,
   input  wire logic         level_indicator_pin_in,
   input  wire logic         filter_start_in,
   // Comb outputs: own channel and partner channel
   input  wire logic [15:0]  comb_i_in,
   input  wire logic [15:0]  comb_q_in,
   input  wire logic         comb_valid_in,
   input  wire logic [15:0]  partner_i_in,
   input  wire logic [15:0]  partner_q_in,
   input  wire logic         partner_valid_in,
   // Formatted filter output
   input  wire logic [15:0]  filt_i_in,
   input  wire logic [15:0]  filt_q_in,
   input  wire logic         filt_valid_in,
   // Memory self-test results from the memories
   input  wire logic         coefficient_memory_fail_in,
   input  wire logic         dmem_fail_in,
   // Configuration out to the datapath
   output logic      [12:0]  resampler_decimation_factor_out,
   output logic      [9:0]   resampler_interpolation_factor_out,
   output logic              exp_invert_out,
   output logic              exp_step_double_out,
   output logic      [4:0]   resampler_scale_out,
   output logic      [8:0]   comb5_decimation_out,
   output logic      [4:0]   comb5_scale_out,
   output logic      [8:0]   coef_filter_decimation_out,
   output logic      [7:0]   coef_filter_phase_select_out,
   output logic      [8:0]   coef_filter_tap_count_out,
   output logic      [7:0]   coef_filter_offset_pointer_out,
   output logic              bypass_out,
   output logic              partner_src_out,
   output logic              coefficient_memory_we_out,
   output logic      [7:0]   coefficient_memory_waddr_out,
   output logic      [19:0]  coefficient_memory_wdata_out,
   output logic              shared_exp_out,
   output logic              force_scale_out,
   output logic      [1:0]   out_format_out,
   output logic      [3:0]   out_scale_out,
   output logic              process_en_out
);
   // Register storage
   logic [11:0] res_dec_reg;        // Resampler decimation minus one
   logic [8:0]  res_int_reg;        // Resampler interpolation minus one
   logic [11:0] res_scale_reg;      // Resampler scale and exponent control
   logic [7:0]  c5_dec_reg;         // Comb decimation minus one
   logic [4:0]  c5_scale_reg;       // Comb scale
   logic [7:0]  cf_dec_reg;         // Filter decimation minus one
   logic [7:0]  cf_phase_reg;       // Phase as written
   logic [7:0]  cf_taps_reg;        // Taps minus one
   logic [7:0]  cf_offset_reg;      // Offset shadow
   logic [10:0] cf_ctrl_reg;        // Filter control
   logic [9:0]  ser_ctrl_reg;       // Serial control, map bit only used here
   logic [15:0] sig_i_reg;          // I signature or mapped data
   logic [15:0] sig_q_reg;          // Q signature or mapped data
   logic [19:0] sig_count_reg;      // Outputs to observe
   logic [19:0] sig_left_reg;       // Outputs still to observe
   cdf_sig_t    sig_state_reg;      // Signature engine state
   logic        mt_busy_reg;        // Memory test running
   logic [10:0] mt_cnt_reg;         // Memory test clock count
   logic [2:0]  mt_stat_reg;        // Start, memory fail flags
   logic        wr_hit;             // Helper decode
   logic [15:0] src_i;              // Observed I sample
   logic [15:0] src_q;              // Observed Q sample
   logic        src_valid;          // Observed sample strobe
   logic [19:0] rd_next;            // Read mux result
   localparam logic [10:0] MT_LAST = 11'(`CDF_MEMTEST_CLKS - 1);
   assign wr_hit = wr_en_in;
   // Host-writable configuration, held until rewritten
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         res_dec_reg   <= 12'h000;
         res_int_reg   <= 9'h000;
         res_scale_reg <= 12'h000;
         c5_dec_reg    <= 8'h00;
         c5_scale_reg  <= 5'h00;
         cf_dec_reg    <= 8'h00;
         cf_phase_reg  <= 8'h00;
         cf_taps_reg   <= 8'h00;
         cf_offset_reg <= 8'h00;
         cf_ctrl_reg   <= 11'h000;
         ser_ctrl_reg  <= 10'h000;
      end
      else if (wr_hit)
      begin
         // Reserved offsets are not stored; host must write them low
         case (addr_in)
            `CDF_ADDR_RES_DEC:   res_dec_reg   <= wdata_in[11:0];
            `CDF_ADDR_RES_INT:   res_int_reg   <= wdata_in[8:0];
            `CDF_ADDR_RES_SCALE: res_scale_reg <= wdata_in[11:0];
            `CDF_ADDR_C5_DEC:    c5_dec_reg    <= wdata_in[7:0];
            `CDF_ADDR_C5_SCALE:  c5_scale_reg  <= wdata_in[4:0];
            `CDF_ADDR_CF_DEC:    cf_dec_reg    <= wdata_in[7:0];
            `CDF_ADDR_CF_PHASE:  cf_phase_reg  <= wdata_in[7:0];
            `CDF_ADDR_CF_TAPS:   cf_taps_reg   <= wdata_in[7:0];
            `CDF_ADDR_CF_OFFSET: cf_offset_reg <= wdata_in[7:0];
            `CDF_ADDR_CF_CTRL:   cf_ctrl_reg   <= wdata_in[10:0];
            `CDF_ADDR_SER_CTRL:  ser_ctrl_reg  <= wdata_in[9:0];
            default:             ;                              // Other offsets ignored
         endcase
      end
   end
   // Factors derived as written value plus one, registered
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         resampler_decimation_factor_out    <= 13'h0001;
         resampler_interpolation_factor_out <= 10'h001;
         comb5_decimation_out               <= 9'h001;
         coef_filter_decimation_out         <= 9'h001;
         coef_filter_tap_count_out          <= 9'h001;
      end
      else
      begin
         // Host guarantees decimation above interpolation; not checked here
         resampler_decimation_factor_out    <= {1'b0, res_dec_reg} + 13'h0001;
         resampler_interpolation_factor_out <= {1'b0, res_int_reg} + 10'h001;
         comb5_decimation_out               <= {1'b0, c5_dec_reg} + 9'h001;
         coef_filter_decimation_out         <= {1'b0, cf_dec_reg} + 9'h001;
         coef_filter_tap_count_out          <= {1'b0, cf_taps_reg} + 9'h001;
      end
   end
   // Resampler scale and exponent control, plus comb scale
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         exp_invert_out      <= 1'b0;
         exp_step_double_out <= 1'b0;
         resampler_scale_out <= 5'h00;
         comb5_scale_out     <= 5'h00;
      end
      else
      begin
         exp_invert_out      <= res_scale_reg[`CDF_SC_EXP_POL];
         exp_step_double_out <= res_scale_reg[`CDF_SC_EXP_WT];
         // Level pin active picks the heavier attenuation field
         if (level_indicator_pin_in)
            resampler_scale_out <= res_scale_reg[9:5];
         else
            resampler_scale_out <= res_scale_reg[4:0];
         comb5_scale_out     <= c5_scale_reg;
      end
   end
   // Phase and offset take effect only at a filter start
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         coef_filter_phase_select_out   <= 8'h00;
         coef_filter_offset_pointer_out <= 8'h00;
      end
      else if (filter_start_in)
      begin
         // Sync does not touch these, so the phase survives it
         coef_filter_phase_select_out   <= cf_phase_reg;
         coef_filter_offset_pointer_out <= cf_offset_reg;
      end
   end
   // Filter control fields out to the datapath
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         bypass_out      <= 1'b0;
         partner_src_out <= 1'b0;
         shared_exp_out  <= 1'b0;
         force_scale_out <= 1'b0;
         out_format_out  <= 2'h0;
         out_scale_out   <= 4'h0;
         process_en_out  <= 1'b0;
      end
      else
      begin
         bypass_out      <= cf_ctrl_reg[`CDF_CTL_BYPASS];
         partner_src_out <= cf_ctrl_reg[`CDF_CTL_SRC];
         shared_exp_out  <= cf_ctrl_reg[`CDF_CTL_SHARED_EXP];
         force_scale_out <= cf_ctrl_reg[`CDF_CTL_FORCE_SCALE];
         out_format_out  <= cf_ctrl_reg[5:4];
         // Scale forwarded always; datapath uses it when fixed or forced
         out_scale_out   <= cf_ctrl_reg[3:0];
         process_en_out  <= !sleep_in;
      end
   end
   // Coefficient writes through the low channel window
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         coefficient_memory_we_out    <= 1'b0;
         coefficient_memory_waddr_out <= 8'h00;
         coefficient_memory_wdata_out <= 20'h00000;
      end
      else
      begin
         coefficient_memory_we_out    <= wr_hit && (addr_in <= `CDF_ADDR_COEF_TOP);
         // Bit 8 only extends the write address, never the filtering
         coefficient_memory_waddr_out <= {cf_ctrl_reg[`CDF_CTL_COEFFICIENT_MEMORY_HI], addr_in[6:0]};
         coefficient_memory_wdata_out <= wdata_in;
      end
   end
   // Signature source: comb output when bypassed, else formatted output
   always_comb
   begin
      if (cf_ctrl_reg[`CDF_CTL_BYPASS])
      begin
         // Partner comb feeds in place of own when source bit set
         if (cf_ctrl_reg[`CDF_CTL_SRC])
         begin
            src_i     = partner_i_in;
            src_q     = partner_q_in;
            src_valid = partner_valid_in;
         end
         else
         begin
            src_i     = comb_i_in;
            src_q     = comb_q_in;
            src_valid = comb_valid_in;
         end
      end
      else
      begin
         src_i     = filt_i_in;
         src_q     = filt_q_in;
         src_valid = filt_valid_in;
      end
   end
   // Signature engine and output mapping
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         sig_i_reg     <= 16'h0000;
         sig_q_reg     <= 16'h0000;
         sig_count_reg <= `CDF_RST_ZERO;
         sig_left_reg  <= `CDF_RST_ZERO;
         sig_state_reg <= CDF_SIG_IDLE;
      end
      else if (ser_ctrl_reg[`CDF_SER_MAP])
      begin
         // Mapped mode: latest output sample readable by host
         sig_state_reg <= CDF_SIG_IDLE;
         if (wr_hit && addr_in == `CDF_ADDR_SIG_COUNT)
            sig_count_reg <= wdata_in;
         if (src_valid)
         begin
            sig_i_reg <= src_i;
            sig_q_reg <= src_q;
         end
      end
      else if (wr_hit && addr_in == `CDF_ADDR_SIG_COUNT)
      begin
         // Loading the count clears and starts the engine
         sig_count_reg <= wdata_in;
         sig_left_reg  <= wdata_in;
         sig_i_reg     <= 16'h0000;
         sig_q_reg     <= 16'h0000;
         sig_state_reg <= (wdata_in == 20'h00000) ? CDF_SIG_DONE : CDF_SIG_RUN;
      end
      else
      begin
         case (sig_state_reg)
            CDF_SIG_RUN:
            begin
               if (src_valid)
               begin
                  // Shift-and-fold signature, one output per step
                  sig_i_reg    <= {sig_i_reg[14:0], sig_i_reg[15] ^ sig_i_reg[4]} ^ src_i;
                  sig_q_reg    <= {sig_q_reg[14:0], sig_q_reg[15] ^ sig_q_reg[4]} ^ src_q;
                  sig_left_reg <= sig_left_reg - 20'h00001;
                  if (sig_left_reg == 20'h00001)
                     sig_state_reg <= CDF_SIG_DONE;
               end
            end
            CDF_SIG_DONE: sig_state_reg <= CDF_SIG_DONE;          // Hold result
            CDF_SIG_IDLE: sig_state_reg <= CDF_SIG_IDLE;
            default:      sig_state_reg <= CDF_SIG_IDLE;
         endcase
      end
   end
   // Memory self-test: starts only while asleep, results after fixed time
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         mt_busy_reg <= 1'b0;
         mt_cnt_reg  <= 11'h000;
         mt_stat_reg <= 3'h0;
      end
      else if (wr_hit && addr_in == `CDF_ADDR_MEM_TEST)
      begin
         // Start only honoured with the channel asleep
         mt_busy_reg <= wdata_in[`CDF_MT_START] && sleep_in;
         mt_cnt_reg  <= 11'h000;
         mt_stat_reg <= {mt_busy_reg & dmem_fail_in, mt_busy_reg & coefficient_memory_fail_in,
                         wdata_in[`CDF_MT_START]};
      end
      else if (mt_busy_reg)
      begin
         // Fail flags are sticky across the run
         mt_stat_reg[`CDF_MT_COEFFICIENT_MEMORY_FAIL] <= mt_stat_reg[`CDF_MT_COEFFICIENT_MEMORY_FAIL] | coefficient_memory_fail_in;
         mt_stat_reg[`CDF_MT_DMEM_FAIL] <= mt_stat_reg[`CDF_MT_DMEM_FAIL] | dmem_fail_in;
         if (mt_cnt_reg == MT_LAST)
         begin
            mt_busy_reg <= 1'b0;
            mt_stat_reg[`CDF_MT_START] <= 1'b0;
         end
         else
            mt_cnt_reg <= mt_cnt_reg + 11'h001;
      end
   end

   // Read mux
   always_comb
   begin
      case (addr_in)
         `CDF_ADDR_RES_DEC:   rd_next = {8'h00, res_dec_reg};
         `CDF_ADDR_RES_INT:   rd_next = {11'h000, res_int_reg};
         `CDF_ADDR_RES_SCALE: rd_next = {8'h00, res_scale_reg};
         `CDF_ADDR_C5_DEC:    rd_next = {12'h000, c5_dec_reg};
         `CDF_ADDR_C5_SCALE:  rd_next = {15'h0000, c5_scale_reg};
         `CDF_ADDR_CF_DEC:    rd_next = {12'h000, cf_dec_reg};
         `CDF_ADDR_CF_PHASE:  rd_next = {12'h000, cf_phase_reg};
         `CDF_ADDR_CF_TAPS:   rd_next = {12'h000, cf_taps_reg};
         `CDF_ADDR_CF_OFFSET: rd_next = {12'h000, cf_offset_reg};
         `CDF_ADDR_CF_CTRL:   rd_next = {9'h000, cf_ctrl_reg};
         `CDF_ADDR_SIG_I:     rd_next = {4'h0, sig_i_reg};
         `CDF_ADDR_SIG_Q:     rd_next = {4'h0, sig_q_reg};
         `CDF_ADDR_SIG_COUNT: rd_next = sig_count_reg;
         `CDF_ADDR_MEM_TEST:  rd_next = {17'h00000, mt_stat_reg};
         `CDF_ADDR_SER_CTRL:  rd_next = {10'h000, ser_ctrl_reg};
         default:             rd_next = 20'h00000;   // Unmapped and reserved read zero
      endcase
   end

   // Registered read data
   always_ff @(posedge clk_in)
   begin
      if (!nrst_in)
      begin
         rdata_out  <= 20'h00000;
         rvalid_out <= 1'b0;
      end
      else
      begin
         rvalid_out <= rd_en_in;
         if (rd_en_in)
            rdata_out <= rd_next;
      end
   end
endmodule : cdf_channel_cfg

// [verification/cdf_cfg_props.sv]
// Checker for the channel configuration block, bound to its ports
// Assumes configuration outputs follow a write by two edges, coefficient writes and reads by one
`timescale 1ns/1ps
`include "cdf_consts.svh"
module cdf_cfg_props
   import cdf_pkg::*;
(
   // Clock, reset, host access
   input wire logic        clk_in,
   input wire logic        nrst_in,
   input wire logic        wr_en_in,
   input wire logic        rd_en_in,
   input wire logic [9:0]  addr_in,
   input wire logic [19:0] wdata_in,
   input wire logic        rvalid_out,
   input wire logic        sleep_in,
   input wire logic        filter_start_in,
   // Watched configuration outputs
   input wire logic [12:0] resampler_decimation_factor_out,
   input wire logic [9:0]  resampler_interpolation_factor_out,
   input wire logic        exp_invert_out,
   input wire logic        exp_step_double_out,
   input wire logic [7:0]  coef_filter_phase_select_out,
   input wire logic [7:0]  coef_filter_offset_pointer_out,
   input wire logic        bypass_out,
   input wire logic        partner_src_out,
   input wire logic        shared_exp_out,
   input wire logic        force_scale_out,
   input wire logic [1:0]  out_format_out,
   input wire logic [3:0]  out_scale_out,
   input wire logic        coefficient_memory_we_out,
   input wire logic [7:0]  coefficient_memory_waddr_out,
   input wire logic [19:0] coefficient_memory_wdata_out,
   input wire logic        process_en_out
);
   // One clock domain only
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // A host write to one location
   sequence s_wr(logic [9:0] a);
      wr_en_in && addr_in == a;
   endsequence
   property p_res_dec;
      s_wr(`CDF_ADDR_RES_DEC) |-> ##2
         resampler_decimation_factor_out == {1'b0, $past(wdata_in[11:0], 2)} + 13'h0001;
   endproperty
   a_res_dec: assert property (p_res_dec) else $error("decimation factor wrong");
   property p_res_int;
      s_wr(`CDF_ADDR_RES_INT) |-> ##2
         resampler_interpolation_factor_out == {1'b0, $past(wdata_in[8:0], 2)} + 10'h001;
   endproperty
   a_res_int: assert property (p_res_int) else $error("interpolation factor wrong");
   property p_exp;
      s_wr(`CDF_ADDR_RES_SCALE) |-> ##2 exp_invert_out == $past(wdata_in[11], 2)
         && exp_step_double_out == $past(wdata_in[10], 2);
   endproperty
   a_exp: assert property (p_exp) else $error("exponent controls wrong");
   // Control bits reach the datapath unchanged
   property p_ctrl;
      s_wr(`CDF_ADDR_CF_CTRL) |-> ##2 {bypass_out, partner_src_out, shared_exp_out,
         force_scale_out, out_format_out, out_scale_out}
         == {$past(wdata_in[10:9], 2), $past(wdata_in[7:0], 2)};
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("control outputs wrong");
   property p_coefficient_memory;
      wr_en_in && addr_in <= `CDF_ADDR_COEF_TOP |=> coefficient_memory_we_out
         && coefficient_memory_waddr_out[6:0] == $past(addr_in[6:0]) && coefficient_memory_wdata_out == $past(wdata_in);
   endproperty
   a_coefficient_memory: assert property (p_coefficient_memory) else $error("coefficient write wrong");
   // Shadowed pointers move only on a filter start
   property p_shadow;
      !filter_start_in |=> $stable(coef_filter_phase_select_out)
         && $stable(coef_filter_offset_pointer_out);
   endproperty
   a_shadow: assert property (p_shadow) else $error("pointer moved without start");
   property p_proc;
      $past(nrst_in) |-> process_en_out == !$past(sleep_in);
   endproperty
   a_proc: assert property (p_proc) else $error("processing enable wrong");
   property p_rvalid;
      $past(nrst_in) |-> rvalid_out == $past(rd_en_in);
   endproperty
   a_rvalid: assert property (p_rvalid) else $error("read valid wrong");
endmodule : cdf_cfg_props
bind cdf_channel_cfg cdf_cfg_props i_props (.*);

// [verification/cdf_sample_src.sv]
// Upstream sample source and memory status for one channel
// Assumes the bench asks for one sample per send pulse
`timescale 1ns/1ps
module cdf_sample_src
   import cdf_pkg::*;
(
   // Clock and bench commands
   input  wire logic        clk_in,
   input  wire logic        send_in,
   input  wire logic [15:0] val_in,
   input  wire logic        fail_in,
   // Toward the block
   output logic      [15:0] data_out,
   output logic             valid_out,
   output logic             fail_out
);
   initial data_out = 16'h0000;
   initial valid_out = 1'b0;
   // Data flips every idle cycle so nothing stale looks valid
   always @(posedge clk_in)
   begin
      valid_out <= send_in;
      data_out  <= send_in ? val_in : ~data_out;
   end
   // Memory fault level stands as long as the bench holds it
   assign fail_out = fail_in;
endmodule : cdf_sample_src

// [verification/cdf_tb.sv]
// Register-level tests of the channel configuration block
// Assumes the sample source model stands in for the datapath
`timescale 1ns/1ps
`include "cdf_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
   import cdf_pkg::*;
   logic clk_in, nrst_in, wr_en, rd_en, sleep, li, fstart, send, fail, rvalid, byp, psrc;
   logic einv, edbl, cwe, shexp, frc, pen, dv, fo;
   logic [9:0]  addr, rint;
   logic [19:0] wdata, rdata, got, cwd, cwd_seen;
   logic [12:0] rdec;
   logic [8:0]  c5dec, cfdec, taps;
   logic [7:0]  phase, offs, cwa, cwa_seen;
   logic [4:0]  rscale, c5sc;
   logic [3:0]  osc;
   logic [1:0]  fmt;
   logic [15:0] val, d, x;
   int n_errors, compares, cycles;
   logic [9:0]  rw_a [10] = '{10'h090, 10'h091, 10'h092, 10'h094, 10'h095,
                              10'h0A0, 10'h0A1, 10'h0A2, 10'h0A3, 10'h0A4};
   logic [19:0] rw_v [10] = '{20'hFFF, 20'h1FF, 20'hC2A, 20'hFF, 20'h1F,
                              20'hFF, 20'h03, 20'h0A, 20'h80, 20'h7FF};
   cdf_sample_src i_src (.clk_in(clk_in), .send_in(send), .val_in(val), .fail_in(fail),
      .data_out(d), .valid_out(dv), .fail_out(fo));
   cdf_channel_cfg i_dut (.clk_in(clk_in), .nrst_in(nrst_in), .wr_en_in(wr_en),
      .rd_en_in(rd_en), .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata),
      .rvalid_out(rvalid), .sleep_in(sleep), .level_indicator_pin_in(li),
      .filter_start_in(fstart), .comb_i_in(d ^ 16'h00FF), .comb_q_in(~d ^ 16'h00FF),
      .comb_valid_in(dv), .partner_i_in(d ^ 16'hFF00), .partner_q_in(~d ^ 16'hFF00),
      .partner_valid_in(dv), .filt_i_in(d), .filt_q_in(~d), .filt_valid_in(dv),
      .coefficient_memory_fail_in(fo), .dmem_fail_in(fo & li), .resampler_decimation_factor_out(rdec),
      .resampler_interpolation_factor_out(rint), .exp_invert_out(einv),
      .exp_step_double_out(edbl), .resampler_scale_out(rscale), .comb5_decimation_out(c5dec),
      .comb5_scale_out(c5sc), .coef_filter_decimation_out(cfdec),
      .coef_filter_phase_select_out(phase), .coef_filter_tap_count_out(taps),
      .coef_filter_offset_pointer_out(offs), .bypass_out(byp), .partner_src_out(psrc),
      .coefficient_memory_we_out(cwe), .coefficient_memory_waddr_out(cwa), .coefficient_memory_wdata_out(cwd), .shared_exp_out(shexp),
      .force_scale_out(frc), .out_format_out(fmt), .out_scale_out(osc), .process_en_out(pen));
   // Clock at 4 ns
   initial
   begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end
   // Last coefficient write seen, plus hang guard
   always @(posedge clk_in)
   begin
      if (cwe === 1'b1) {cwa_seen, cwd_seen} <= {cwa, cwd};
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         summarize();
      end
   end
   // Signature fold step
   function automatic logic [15:0] fold(logic [15:0] s, logic [15:0] v);
      return {s[14:0], s[15] ^ s[4]} ^ v;
   endfunction : fold
   // Write, then wait until the outputs have settled
   task automatic wr(logic [9:0] a, logic [19:0] v);
      @(negedge clk_in);
      {wr_en, addr, wdata} = {1'b1, a, v};
      @(negedge clk_in);
      wr_en = 1'b0;
      @(negedge clk_in);
   endtask : wr
   task automatic rd(logic [9:0] a, output logic [19:0] v);
      @(negedge clk_in);
      {rd_en, addr} = {1'b1, a};
      @(negedge clk_in);
      rd_en = 1'b0;
      `CHK(rvalid, 1'b1)
      v = rdata;
   endtask : rd
   task automatic snd(logic [15:0] v);
      @(negedge clk_in);
      {send, val} = {1'b1, v};
      @(negedge clk_in);
      send = 1'b0;
      repeat (2) @(negedge clk_in);
   endtask : snd
   task automatic summarize();
      $display("errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   initial
   begin
      {nrst_in, wr_en, rd_en, addr, wdata, sleep, li, fstart, send, val, fail} = '0;
      repeat (3) @(negedge clk_in);
      nrst_in = 1'b1;
      `CHK(rdec, 13'h0001)
      for (int k = 0; k < 10; k++)
      begin
         rd(rw_a[k], got);
         `CHK(got, 20'h0)
         wr(rw_a[k], rw_v[k]);
         rd(rw_a[k], got);
         `CHK(got, rw_v[k])
      end
      `CHK({rdec, rint}, {13'h1000, 10'h200})
      `CHK({einv, edbl, c5dec, cfdec, taps}, {2'b11, 9'h100, 9'h100, 9'h00B})
      `CHK(c5sc, 5'h1F)
      `CHK({phase, offs}, 16'h0000)
      @(negedge clk_in) fstart = 1'b1;
      @(negedge clk_in) fstart = 1'b0;
      `CHK({phase, offs}, 16'h0380)
      li = 1'b1;
      repeat (2) @(negedge clk_in);
      `CHK(rscale, 5'h01)
      li = 1'b0;
      repeat (2) @(negedge clk_in);
      `CHK(rscale, 5'h0A)
      wr(10'h093, 20'h0);
      rd(10'h093, got);
      `CHK(got, 20'h0)
      rd(10'h3FF, got);
      `CHK(got, 20'h0)
      for (int k = 0; k < 4; k++)
      begin
         wr(10'h0A4, 20'(20'h2C0 | (k << 4) | k));
         `CHK({byp, psrc, shexp, frc, fmt, osc}, {4'b0111, k[1:0], k[3:0]})
      end
      wr(10'h0A4, 20'h100);
      wr(10'h005, 20'hABCDE);
      `CHK({cwa_seen, cwd_seen}, {8'h85, 20'hABCDE})
      wr(10'h0A9, 20'h200);
      wr(10'h0A4, 20'h0);
      snd(16'h1234);
      rd(10'h0A5, got);
      `CHK(got, 20'h01234)
      rd(10'h0A6, got);
      `CHK(got, 20'h0EDCB)
      wr(10'h0A4, 20'h400);
      snd(16'h1234);
      rd(10'h0A5, got);
      `CHK(got, 20'h012CB)
      wr(10'h0A4, 20'h600);
      snd(16'h1234);
      rd(10'h0A5, got);
      `CHK(got, 20'h0ED34)
      wr(10'h0A9, 20'h0);
      wr(10'h0A4, 20'h0);
      wr(10'h0A7, 20'h2);
      snd(16'h8011);
      snd(16'h0F0F);
      snd(16'h5555);
      x = fold(fold(16'h0, 16'h8011), 16'h0F0F);
      rd(10'h0A5, got);
      `CHK(got, {4'h0, x})
      x = fold(fold(16'h0, 16'h7FEE), 16'hF0F0);
      rd(10'h0A6, got);
      `CHK(got, {4'h0, x})
      {sleep, fail} = 2'b11;
      wr(10'h0A8, 20'h1);
      `CHK(pen, 1'b0)
      rd(10'h0A8, got);
      `CHK(got, 20'h3)
      li = 1'b1;
      repeat (1600) @(negedge clk_in);
      rd(10'h0A8, got);
      `CHK(got, 20'h6)
      sleep = 1'b0;
      repeat (2) @(negedge clk_in);
      `CHK(pen, 1'b1)
      summarize();
   end
endmodule : tb
